//--- framer_regs_pkg.sv
// Constants and carrier types shared by the framer control and status block
package framer_regs_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_MSG_CTRL_B = 8'h0B;
	localparam logic [7:0] ADDR_CHAN_STAT_A = 8'h0C;
	localparam logic [7:0] RESET_MSG_CTRL = 8'h00;
	localparam logic [1:0] RESET_CHAN_CTRL = 2'h0;

	// ------------------------------------------------------------------
	// Field positions in message_control_b
	// ------------------------------------------------------------------
	localparam int BIT_DELETE_ON_ERROR = 7;
	localparam int BIT_HOST_CHECKSUM_VERIFY = 6;
	localparam int BIT_INSERT_CHECKSUM = 5;
	localparam int BIT_TX_SIZE_CHECK = 4;
	localparam int BIT_KEEP_MESSAGE = 3;
	localparam int BIT_RX_CHECKSUM_CHECK = 2;
	localparam int BIT_MESSAGE_READY_MODE = 1;
	localparam int BIT_LINE_INVERT = 0;

	// ------------------------------------------------------------------
	// Field positions in channel_status_a
	// ------------------------------------------------------------------
	localparam int BIT_CHANNEL_SOFT_RESET = 7;
	localparam int BIT_FRAMER_ENABLE = 6;
	localparam int BIT_LATCHED_LOW = 3;
	localparam int BIT_LIVE_LOW = 0;

	// ------------------------------------------------------------------
	// Message checksum and timing
	// ------------------------------------------------------------------
	localparam int CHECKSUM_WIDTH = 6;
	localparam logic [7:0] CHECKSUM_SEED = 8'h52;
	localparam int SOFT_RESET_CYCLES = 2;

	// Host register access, one request per cycle
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Live fault inputs of the first channel
	typedef struct packed {
		logic currentLimit;
		logic underVoltage;
		logic driverFault;
	} fault_t;

endpackage : framer_regs_pkg

//--- msg_checksum.sv
// Six-bit message checksum folded from an 8-bit running accumulator
`timescale 1ns/100ps
module msg_checksum (
	// Accumulated message octets, check octet bits under check masked
	input wire logic [7:0] accum,
	// Resulting six-bit checksum
	output logic [5:0] checksum
);

	// ------------------------------------------------------------------
	// Fold the eight-bit xor into six bits: odd and even bit parity, then four bit pairs
	// ------------------------------------------------------------------
	always_comb begin
		checksum[5] = accum[7] ^ accum[5] ^ accum[3] ^ accum[1];
		checksum[4] = accum[6] ^ accum[4] ^ accum[2] ^ accum[0];
		checksum[3] = accum[7] ^ accum[6];
		checksum[2] = accum[5] ^ accum[4];
		checksum[1] = accum[3] ^ accum[2];
		checksum[0] = accum[1] ^ accum[0];
	end

endmodule : msg_checksum

//--- framer_msg_ctrl.sv
// Message control of the second channel and channel status of the first
//
// Overview of operation
// - Delete-on-error flushes queue on checksum/size error
// - Host checksum mismatch sets transmit checksum error
// - Insert checksum replaces six check-octet bits
// - Size check mismatch raises transmit error unless sending began early
// - No auto delete once sending began early
// - Keep-message retains queue; host flushes it
// - Without keep-message, queue empties after sending
// - Receive checksum check sets receive error flag
// - Ready interrupt: whole clean message or first word
// - Line invert clear makes pins line inverse
// - Soft reset clears framer enable and latched flags, self-clears
// - Framer enable activates handler and queues
// - Latched flags set on rising edge, clear-on-read
// - Current-limit live flag follows supply limiter
// - Undervoltage live flag follows supply monitor
// - Driver fault live flag follows line driver
// - Receive checksum error clears on error-register read
`timescale 1ns/100ps
module framer_msg_ctrl #(
	parameter int RESET_CYCLES = framer_regs_pkg::SOFT_RESET_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Host register access
	input wire framer_regs_pkg::reg_req_t regReq,
	output logic [7:0] regRdata,
	// Channel error register read strobe from the error register
	input wire logic errorRegRead,
	// Live faults of the first channel, asynchronous pins
	input wire framer_regs_pkg::fault_t faultPin,
	// Transmit message events of the second channel
	input wire logic txOctetValid,
	input wire logic [7:0] txOctet,
	input wire logic txCheckOctet,
	input wire logic txLoadDone,
	input wire logic [7:0] txByteCount,
	input wire logic txStart,
	input wire logic txSent,
	// Receive message events of the second channel
	input wire logic rxOctetValid,
	input wire logic [7:0] rxOctet,
	input wire logic rxCheckOctet,
	input wire logic rxDone,
	input wire logic rxOtherError,
	// Second channel line and logic pins
	input wire logic lineIn,
	input wire logic txLogic,
	output logic rxLogic,
	output logic lineOut,
	// Second channel queue controls and results
	output logic txQueueFlush,
	output logic [7:0] checkOctetOut,
	output logic transmitChecksumError,
	output logic receiveChecksumError,
	output logic transmitErrorIrq,
	output logic receiveDataReadyIrq,
	// First channel controls
	output logic framerEnableA,
	output logic channelResetA
);

	// ------------------------------------------------------------------
	// Module state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] msgCtrl;
		logic framerEnable;
		logic softReset;
		logic [3:0] resetCount;
		logic [2:0] liveMeta;
		logic [2:0] liveSync;
		logic [2:0] livePrev;
		logic [2:0] latched;
		logic [7:0] txAccum;
		logic [7:0] txCheck;
		logic [7:0] txCount;
		logic txLoaded;
		logic txEarly;
		logic [7:0] rxAccum;
		logic [7:0] rxCount;
		logic [5:0] rxCheck;
		logic txChkErr;
		logic rxChkErr;
		logic txErrIrq;
		logic rxRdyIrq;
		logic flush;
		logic [7:0] rdata;
		logic lineSync0;
		logic lineSync1;
	} state_t;

	// Seed of both message accumulators
	localparam logic [7:0] CHECKSEED = framer_regs_pkg::CHECKSUM_SEED;

	state_t cur;
	state_t next_cur;
	logic [5:0] txSum;
	logic [5:0] rxSum;
	logic [7:0] ctrl;
	logic txSizeBad;
	logic txSumBad;

	// Checksum of the transmit message
	msg_checksum txChecksum (
		.accum(cur.txAccum),
		.checksum(txSum)
	);

	// Checksum of the received message
	msg_checksum rxChecksum (
		.accum(cur.rxAccum),
		.checksum(rxSum)
	);

	assign ctrl = cur.msgCtrl;
	assign txSizeBad = ctrl[framer_regs_pkg::BIT_TX_SIZE_CHECK]
		&& (cur.txCount != txByteCount);
	assign txSumBad = ctrl[framer_regs_pkg::BIT_HOST_CHECKSUM_VERIFY]
		&& (cur.txCheck[5:0] != txSum);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		logic readStat;
		logic delErr;
		logic [7:0] accBase;
		logic [7:0] cntBase;
		readStat = 1'b0;
		delErr = 1'b0;
		// A load after a finished message starts from scratch
		accBase = cur.txLoaded ? CHECKSEED : cur.txAccum;
		cntBase = cur.txLoaded ? 8'h00 : cur.txCount;
		next_cur = cur;
		next_cur.flush = 1'b0;
		next_cur.txErrIrq = 1'b0;
		next_cur.rxRdyIrq = 1'b0;

		// Fault pins pass two flops before use
		next_cur.liveMeta = faultPin;
		next_cur.liveSync = cur.liveMeta;
		next_cur.livePrev = cur.liveSync;
		next_cur.lineSync0 = lineIn;
		next_cur.lineSync1 = cur.lineSync0;

		// Register writes, address decode
		if (regReq.write) begin
			if (regReq.addr == framer_regs_pkg::ADDR_MSG_CTRL_B) begin
				next_cur.msgCtrl = regReq.wdata;
			end else if (regReq.addr == framer_regs_pkg::ADDR_CHAN_STAT_A) begin
				next_cur.framerEnable =
					regReq.wdata[framer_regs_pkg::BIT_FRAMER_ENABLE];
				if (regReq.wdata[framer_regs_pkg::BIT_CHANNEL_SOFT_RESET]) begin
					next_cur.softReset = 1'b1;
					next_cur.resetCount = 4'h0;
				end
			end
		end

		// Register reads; only status read has a side effect
		next_cur.rdata = 8'h00;
		if (regReq.read) begin
			if (regReq.addr == framer_regs_pkg::ADDR_MSG_CTRL_B) begin
				next_cur.rdata = cur.msgCtrl;
			end else if (regReq.addr == framer_regs_pkg::ADDR_CHAN_STAT_A) begin
				next_cur.rdata = {cur.softReset, cur.framerEnable,
					cur.latched, cur.liveSync};
				readStat = 1'b1;
			end
		end

		// Latched flags: clear on read, but a new edge wins
		if (readStat) begin
			next_cur.latched = 3'h0;
		end
		next_cur.latched = next_cur.latched
			| (cur.liveSync & ~cur.livePrev);

		// Soft reset of the first channel, self clearing
		if (cur.softReset) begin
			next_cur.framerEnable = 1'b0;
			next_cur.latched = 3'h0;
			next_cur.resetCount = cur.resetCount + 4'h1;
			if (cur.resetCount == 4'(RESET_CYCLES - 1)) begin
				next_cur.softReset = 1'b0;
			end
		end

		// Transmit message collection
		if (txOctetValid) begin
			// Without this a stale early flag would leak into the next message
			if (cur.txLoaded) begin
				next_cur.txLoaded = 1'b0;
				next_cur.txEarly = 1'b0;
			end
			next_cur.txCount = cntBase + 8'h01;
			if (txCheckOctet) begin
				next_cur.txCheck = txOctet;
				// Only the two type bits take part in the sum
				next_cur.txAccum = accBase ^ {txOctet[7:6], 6'h00};
			end else begin
				next_cur.txAccum = accBase ^ txOctet;
			end
		end
		if (txStart && !cur.txLoaded) begin
			next_cur.txEarly = 1'b1;
		end

		// Checks when the whole message is loaded
		if (txLoadDone) begin
			next_cur.txLoaded = 1'b1;
			if (txSumBad) begin
				next_cur.txChkErr = 1'b1;
			end
			if (txSizeBad && !cur.txEarly) begin
				next_cur.txErrIrq = 1'b1;
			end
			delErr = (txSumBad || txSizeBad) && !cur.txEarly;
			if (delErr && ctrl[framer_regs_pkg::BIT_DELETE_ON_ERROR]) begin
				next_cur.flush = 1'b1;
			end
		end

		// After sending, keep or drop the message
		if (txSent) begin
			next_cur.txLoaded = 1'b0;
			next_cur.txEarly = 1'b0;
			if (!ctrl[framer_regs_pkg::BIT_KEEP_MESSAGE]) begin
				next_cur.flush = 1'b1;
			end
		end

		// A flush restarts the transmit accumulator and byte count
		if (next_cur.flush && !ctrl[framer_regs_pkg::BIT_KEEP_MESSAGE]) begin
			next_cur.txAccum = CHECKSEED;
			next_cur.txCount = 8'h00;
		end else if (next_cur.flush) begin
			next_cur.txAccum = CHECKSEED;
			next_cur.txCount = 8'h00;
		end

		// Receive message collection
		if (rxOctetValid) begin
			next_cur.rxCount = cur.rxCount + 8'h01;
			if (cur.rxCount == 8'h00
				&& !ctrl[framer_regs_pkg::BIT_MESSAGE_READY_MODE]) begin
				next_cur.rxRdyIrq = 1'b1;
			end
			if (rxCheckOctet) begin
				next_cur.rxAccum = cur.rxAccum ^ {rxOctet[7:6], 6'h00};
				next_cur.rxCheck = rxOctet[5:0]; // Held until message end
			end else begin
				next_cur.rxAccum = cur.rxAccum ^ rxOctet;
			end
		end
		if (rxDone) begin
			next_cur.rxCount = 8'h00;
			next_cur.rxAccum = CHECKSEED;
			if (ctrl[framer_regs_pkg::BIT_RX_CHECKSUM_CHECK]
				&& rxSum != cur.rxCheck) begin
				next_cur.rxChkErr = 1'b1;
			end else if (ctrl[framer_regs_pkg::BIT_MESSAGE_READY_MODE]
				&& !rxOtherError) begin
				next_cur.rxRdyIrq = 1'b1;
			end
		end

		// Error flags clear on error-register read; a set wins
		if (errorRegRead) begin
			next_cur.txChkErr = txLoadDone && txSumBad;
			next_cur.rxChkErr = next_cur.rxChkErr && rxDone;
		end

		// Synchronous reset
		if (sys_rst) begin
			next_cur = '0;
			next_cur.msgCtrl = framer_regs_pkg::RESET_MSG_CTRL;
			next_cur.txAccum = CHECKSEED;
			next_cur.rxAccum = CHECKSEED;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		cur <= next_cur;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Inverting line drivers: default setting presents the inverse
	assign rxLogic = ctrl[framer_regs_pkg::BIT_LINE_INVERT]
		? cur.lineSync1 : ~cur.lineSync1;
	assign lineOut = ctrl[framer_regs_pkg::BIT_LINE_INVERT]
		? txLogic : ~txLogic;
	// Check octet sent on the line, checksum inserted when asked
	assign checkOctetOut = ctrl[framer_regs_pkg::BIT_INSERT_CHECKSUM]
		? {cur.txCheck[7:6], txSum} : cur.txCheck;
	assign regRdata = cur.rdata;
	assign txQueueFlush = cur.flush;
	assign transmitChecksumError = cur.txChkErr;
	assign receiveChecksumError = cur.rxChkErr;
	assign transmitErrorIrq = cur.txErrIrq;
	assign receiveDataReadyIrq = cur.rxRdyIrq;
	assign framerEnableA = cur.framerEnable;
	assign channelResetA = cur.softReset;

endmodule : framer_msg_ctrl

//--- framer_msg_ctrl_sva.sv
// Concurrent checks on the framer control and status block ports
`timescale 1ns/100ps
module framer_msg_ctrl_sva #(
	parameter int RESET_CYCLES = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Host access
	input wire framer_regs_pkg::reg_req_t regReq,
	input wire logic [7:0] regRdata,
	input wire logic errorRegRead,
	// Message events
	input wire logic txLoadDone,
	input wire logic txSent,
	input wire logic rxDone,
	input wire logic rxOtherError,
	input wire logic txLogic,
	// Results
	input wire logic lineOut,
	input wire logic txQueueFlush,
	input wire logic transmitChecksumError,
	input wire logic receiveChecksumError,
	input wire logic receiveDataReadyIrq,
	input wire logic framerEnableA,
	input wire logic channelResetA
);
	logic [7:0] ctrlShadow;
	logic [7:0] rstCount;
	logic hitB;
	logic hitC;
	assign hitB = regReq.addr == framer_regs_pkg::ADDR_MSG_CTRL_B;
	assign hitC = regReq.addr == framer_regs_pkg::ADDR_CHAN_STAT_A;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Shadow of the control register and length of the soft reset pulse
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrlShadow <= 8'h00;
		end else if (regReq.write && hitB) begin
			ctrlShadow <= regReq.wdata;
		end
		rstCount <= (sys_rst || !channelResetA) ? 8'h00 : rstCount + 8'h01;
	end

	sequence s_ctrl_read;
		regReq.read && hitB;
	endsequence
	sequence s_fen_write;
		regReq.write && hitC && !regReq.wdata[7];
	endsequence

	a_ctrl_read_back: assert property (s_ctrl_read |=>
		regRdata == $past(ctrlShadow)) else $error("control readback wrong");
	a_stray_read_zero: assert property (!(regReq.read && (hitB || hitC))
		|=> regRdata == 8'h00) else $error("read data not zero");
	a_line_polarity: assert property (
		lineOut == (ctrlShadow[0] ? txLogic : !txLogic)) else $error("line pin");
	a_reset_length: assert property ($fell(channelResetA) |->
		rstCount == RESET_CYCLES) else $error("soft reset length");
	a_reset_clears_fen: assert property ($fell(channelResetA)
		|-> !framerEnableA) else $error("framer enable kept");
	a_fen_write: assert property (s_fen_write |=>
		framerEnableA == $past(regReq.wdata[6])) else $error("framer enable");
	a_ready_clean: assert property (ctrlShadow[1] && receiveDataReadyIrq
		|-> $past(rxDone) && !$past(rxOtherError)) else $error("early ready");
	a_flush_after_sent: assert property (txSent && !ctrlShadow[3]
		|=> txQueueFlush) else $error("no flush after send");
	a_error_read_clear: assert property (errorRegRead && !rxDone
		&& !txLoadDone |=> !receiveChecksumError && !transmitChecksumError)
		else $error("error flag not cleared");
endmodule : framer_msg_ctrl_sva

bind framer_msg_ctrl framer_msg_ctrl_sva #(.RESET_CYCLES(RESET_CYCLES))
	u_framer_msg_ctrl_sva (.*);

//--- field_device.sv
// Field device answering on the sensor line of the second channel
`timescale 1ns/100ps
module field_device (
	// Clock
	input wire logic clk,
	// Received message events and line level
	output logic rxOctetValid,
	output logic [7:0] rxOctet,
	output logic rxCheckOctet,
	output logic rxDone,
	output logic rxOtherError,
	output logic lineIn
);
	// Fold of an accumulator into six checksum bits
	function automatic logic [5:0] fold(input logic [7:0] a);
		fold = {a[7] ^ a[5] ^ a[3] ^ a[1], a[6] ^ a[4] ^ a[2] ^ a[0],
			a[7] ^ a[6], a[5] ^ a[4], a[3] ^ a[2], a[1] ^ a[0]};
	endfunction : fold

	// Idle line sits high between messages
	initial begin
		{rxOctetValid, rxCheckOctet, rxDone, rxOtherError} = 4'h0;
		rxOctet = 8'h00;
		lineIn = 1'b1;
	end

	// Two data octets and a check octet; gap makes a slow answer
	task automatic respond(input logic bad, input logic other, input int gap);
		logic [7:0] msg [3];
		msg = '{8'h33, 8'h44, {2'b00, fold(8'h25)} ^ {7'h00, bad}};
		for (int i = 0; i < 3; i++) begin
			@(negedge clk) rxOctetValid = 1'b1;
			rxOctet = msg[i];
			rxCheckOctet = (i == 2);
			lineIn = msg[i][0];
			@(negedge clk) rxOctetValid = 1'b0;
			rxOctet = ~msg[i]; // Stale data never looks valid
			repeat (gap) @(negedge clk);
		end
		{rxCheckOctet, rxDone, rxOtherError} = {2'b01, other};
		@(negedge clk) {rxDone, rxOtherError, lineIn} = 3'b001;
	endtask : respond
endmodule : field_device

//--- framer_msg_ctrl_test.sv
// Self-checking bench for the framer control and status block
`timescale 1ns/100ps
module framer_msg_ctrl_test;
	framer_regs_pkg::reg_req_t regReq;
	framer_regs_pkg::fault_t faultPin;
	logic clk, sys_rst, errorRegRead, txOctetValid, txCheckOctet, txLoadDone;
	logic txStart, txSent, lineIn, txLogic, rxLogic, lineOut, txQueueFlush;
	logic rxOctetValid, rxCheckOctet, rxDone, rxOtherError, framerEnableA;
	logic transmitChecksumError, receiveChecksumError, transmitErrorIrq;
	logic receiveDataReadyIrq, channelResetA;
	logic [7:0] regRdata, txOctet, txByteCount, rxOctet, checkOctetOut, ck;
	int errors = 0, comparisons = 0, cycles = 0;
	int nFlush = 0, nTxIrq = 0, nRdy = 0;

	framer_msg_ctrl #(.RESET_CYCLES(2)) u_framer_msg_ctrl (.*);
	field_device u_field_device (.*);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Pulse counters; the ceiling cuts a hang short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (txQueueFlush === 1'b1) nFlush <= nFlush + 1;
		if (transmitErrorIrq === 1'b1) nTxIrq <= nTxIrq + 1;
		if (receiveDataReadyIrq === 1'b1) nRdy <= nRdy + 1;
		if (cycles == 3000) begin
			errors = errors + 1;
			wrap_up();
		end
	end

	task automatic check(input string w, input logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk) regReq = '{1'b1, 1'b0, a, d};
		@(negedge clk) regReq = '0;
	endtask : wr

	// Read data is valid in the cycle after the taking edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
		@(negedge clk) regReq = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk) regReq = '0;
		check(w, e, regRdata);
	endtask : rd

	// Octets 11h, 22h and a check octet; early starts sending midway
	task automatic load(input logic [7:0] c, input logic [7:0] n, input logic e);
		for (int i = 0; i < 3; i++) begin
			@(negedge clk) txOctetValid = 1'b1;
			txOctet = (i == 0) ? 8'h11 : (i == 1) ? 8'h22 : c;
			{txCheckOctet, txStart} = {i == 2, e && i == 1};
		end
		@(negedge clk) {txOctetValid, txCheckOctet, txLoadDone} = 3'b001;
		txByteCount = n;
		@(negedge clk) txLoadDone = 1'b0;
		repeat (3) @(negedge clk);
	endtask : load

	task automatic wrap_up();
		$display("Comparisons %0d, errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	initial begin
		{regReq, faultPin, txOctet, txByteCount} = '0;
		{errorRegRead, txOctetValid, txCheckOctet, txLoadDone} = 4'h0;
		{txStart, txSent, txLogic, sys_rst} = 4'h1;
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		rd(8'h0B, 8'h00, "control reset");
		rd(8'h0C, 8'h00, "status reset");
		rd(8'h05, 8'h00, "unmapped");
		wr(8'h0B, 8'hA5);
		rd(8'h0B, 8'hA5, "control");
		for (int v = 0; v < 2; v++) begin
			wr(8'h0B, {7'h00, v[0]});
			txLogic = 1'b1;
			repeat (4) @(negedge clk);
			check("tx pin", {7'h0, v[0]}, {7'h0, lineOut});
			check("rx pin", {7'h0, lineIn ~^ v[0]}, {7'h0, rxLogic});
		end
		// Each fault: latched on the rise, cleared by the read, live stays
		for (int i = 0; i < 3; i++) begin
			faultPin = 3'(3'b100 >> i);
			repeat (4) @(negedge clk);
			rd(8'h0C, 8'(8'h24 >> i), "fault rise");
			rd(8'h0C, 8'(8'h04 >> i), "fault held");
			faultPin = '0;
			repeat (4) @(negedge clk);
			rd(8'h0C, 8'h00, "fault gone");
		end
		wr(8'h0C, 8'h40);
		rd(8'h0C, 8'h40, "framer enable");
		wr(8'h0C, 8'hC0);
		repeat (4) @(negedge clk);
		rd(8'h0C, 8'h00, "soft reset");
		rd(8'h0B, 8'h01, "other channel");
		wr(8'h0B, 8'h90);
		load(8'h40, 8'hFF, 1'b0);
		check("size irq", 8'h01, 8'(nTxIrq));
		check("delete", 8'h01, 8'(nFlush));
		load(8'h40, 8'hFF, 1'b1);
		check("early", 8'h02, 8'(nTxIrq + nFlush));
		ck = {2'b01, u_field_device.fold(8'h21)};
		wr(8'h0B, 8'h40);
		load(ck, 8'h03, 1'b0);
		check("cs good", 8'h00, {7'h0, transmitChecksumError});
		load(ck ^ 8'h01, 8'h03, 1'b0);
		check("cs bad", 8'h01, {7'h0, transmitChecksumError});
		wr(8'h0B, 8'h20);
		load(8'hBF, 8'h03, 1'b0);
		ck = {2'b10, u_field_device.fold(8'hE1)};
		check("insert", ck, checkOctetOut);
		for (int k = 0; k < 2; k++) begin
			wr(8'h0B, k ? 8'h00 : 8'h08);
			@(negedge clk) txSent = 1'b1;
			@(negedge clk) txSent = 1'b0;
			@(negedge clk) check("flush", 8'(1 + k), 8'(nFlush));
		end
		// Good, bad checksum, slow clean, other error; reads clear flags
		for (int k = 0; k < 4; k++) begin
			wr(8'h0B, k < 2 ? 8'h04 : 8'h06);
			u_field_device.respond(k == 1, k == 3, k * 2);
			repeat (3) @(negedge clk);
			check("ready", 8'(k < 3 ? k + 1 : 3), 8'(nRdy));
			check("rx cs", {7'h0, k == 1}, {7'h0, receiveChecksumError});
			@(negedge clk) errorRegRead = 1'b1;
			@(negedge clk) errorRegRead = 1'b0;
		end
		check("tx cs clear", 8'h00, {7'h0, transmitChecksumError});
		wrap_up();
	end
endmodule : framer_msg_ctrl_test
